// ### design/fts_pkg.sv
// constants, types and helpers for the track-image host
// assumes one 250 MHz clock; byte counts follow the two standard layouts
package fts_pkg;
    localparam int CLK_NS    = 4;
    localparam int T_DS_NS   = 150;
    localparam int T_WE_NS   = 200;
    localparam int T_DH_NS   = 50;
    localparam int T_DRR_NS  = 200;
    // least times, rounded up to whole cycles
    localparam int DS_CYC    = (T_DS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_CYC    = (T_WE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DH_CYC    = (T_DH_NS + CLK_NS - 1) / CLK_NS;
    localparam int DRR_CYC   = (T_DRR_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0] B_FILL_FM  = 8'hff;
    localparam logic [7:0] B_FILL_MFM = 8'h4e;
    localparam logic [7:0] B_ZERO     = 8'h00;
    localparam logic [7:0] B_IAM      = 8'hfc;
    localparam logic [7:0] B_IDAM     = 8'hfe;
    localparam logic [7:0] B_DAM      = 8'hfb;
    localparam logic [7:0] B_CRC      = 8'hf7;
    localparam logic [7:0] B_SYNC_A1  = 8'hf5;
    localparam logic [7:0] B_SYNC_C2  = 8'hf6;

    localparam logic [10:0] N_ONE      = 11'h001;
    localparam logic [10:0] N_NONE     = 11'h000;
    localparam logic [10:0] N_GAP0_FM  = 11'h028;
    localparam logic [10:0] N_GAP0_MFM = 11'h050;
    localparam logic [10:0] N_SYNC_FM  = 11'h006;
    localparam logic [10:0] N_SYNC_MFM = 11'h00c;
    localparam logic [10:0] N_MARK_PRE = 11'h003;
    localparam logic [10:0] N_GAP1_FM  = 11'h01a;
    localparam logic [10:0] N_GAP1_MFM = 11'h032;
    localparam logic [10:0] N_GAP2_FM  = 11'h00b;
    localparam logic [10:0] N_GAP2_MFM = 11'h016;
    localparam logic [10:0] N_GAP3_FM  = 11'h01b;
    localparam logic [10:0] N_GAP3_MFM = 11'h036;
    localparam logic [10:0] N_DATA_MIN = 11'h080;
    localparam logic [4:0]  SECTORS    = 5'h1a;
    localparam logic [4:0]  FIRST_SEC  = 5'h01;

    typedef enum logic [4:0] {
        SG_GAP0 = 5'b00000, SG_SYNC0 = 5'b00001, SG_IAMPRE = 5'b00010,
        SG_IAM  = 5'b00011, SG_GAP1  = 5'b00100, SG_IDSYNC = 5'b00101,
        SG_IDA1 = 5'b00110, SG_IDAM  = 5'b00111, SG_TRK    = 5'b01000,
        SG_SIDE = 5'b01001, SG_SEC   = 5'b01010, SG_LEN    = 5'b01011,
        SG_IDCRC = 5'b01100, SG_GAP2 = 5'b01101, SG_DSYNC  = 5'b01110,
        SG_DA1  = 5'b01111, SG_DAM   = 5'b10000, SG_DATA   = 5'b10001,
        SG_DCRC = 5'b10010, SG_GAP3  = 5'b10011, SG_GAP4   = 5'b10100
    } fts_seg_type;

    function automatic logic [10:0] fts_seg_len(fts_seg_type s, logic dbl,
                                                 logic omit, logic [1:0] sz);
        case (s)
            SG_GAP0:   fts_seg_len = dbl ? N_GAP0_MFM : N_GAP0_FM;
            SG_SYNC0:  fts_seg_len = omit ? N_NONE : (dbl ? N_SYNC_MFM : N_SYNC_FM);
            SG_IAMPRE: fts_seg_len = (dbl && !omit) ? N_MARK_PRE : N_NONE;
            SG_IAM:    fts_seg_len = omit ? N_NONE : N_ONE;
            SG_GAP1:   fts_seg_len = dbl ? N_GAP1_MFM : N_GAP1_FM; // RULE_13
            SG_IDSYNC, SG_DSYNC: fts_seg_len = dbl ? N_SYNC_MFM : N_SYNC_FM; // RULE_14 RULE_15
            SG_IDA1, SG_DA1:     fts_seg_len = dbl ? N_MARK_PRE : N_NONE;
            SG_GAP2:   fts_seg_len = dbl ? N_GAP2_MFM : N_GAP2_FM; // RULE_14 RULE_15
            SG_DATA:   fts_seg_len = 11'(N_DATA_MIN << sz);
            // standard gap lengths only: shorter gaps trade away splice margin
            SG_GAP3:   fts_seg_len = dbl ? N_GAP3_MFM : N_GAP3_FM; // RULE_13 RULE_16
            default:   fts_seg_len = N_ONE;
        endcase
    endfunction
endpackage

// ### design/fts_wr_if.sv
// byte hand-off between the image sequencer and the write-strobe engine
// both ends sit in the one clock domain of the host
`timescale 1ns/10ps
interface fts_wr_if;
    logic       go;
    logic [7:0] data;
    logic       busy;
    logic       done;
    modport master (output go, output data, input busy, input done);
    modport slave  (input go, input data, output busy, output done);
endinterface

// ### design/fts_layout.sv
// byte generator: maps the current segment to the byte to load
// assumes segment and settings hold steady one cycle before use
`timescale 1ns/10ps
module fts_layout
    import fts_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire fts_seg_type i_seg,
    input  wire logic        i_dbl,
    input  wire logic        i_fill_zero,
    input  wire logic [7:0]  i_track,
    input  wire logic [7:0]  i_side,
    input  wire logic [4:0]  i_sector,
    input  wire logic [1:0]  i_size_code,
    input  wire logic [7:0]  i_pattern,
    output logic      [7:0]  o_byte
);
    logic [7:0] next_byte;
    logic [7:0] fill;

    always_comb begin
        fill = i_dbl ? B_FILL_MFM : (i_fill_zero ? B_ZERO : B_FILL_FM); // RULE_06
        case (i_seg)
            SG_GAP0, SG_GAP1, SG_GAP2, SG_GAP3, SG_GAP4: next_byte = fill;
            SG_IAMPRE:          next_byte = B_SYNC_C2; // RULE_07
            SG_IAM:             next_byte = B_IAM;
            SG_IDA1, SG_DA1:    next_byte = B_SYNC_A1; // RULE_11
            SG_IDAM:            next_byte = B_IDAM;
            SG_TRK:             next_byte = i_track;
            SG_SIDE:            next_byte = i_side;
            SG_SEC:             next_byte = {3'h0, i_sector};
            SG_LEN:             next_byte = {6'h00, i_size_code};
            SG_IDCRC, SG_DCRC:  next_byte = B_CRC;
            SG_DAM:             next_byte = B_DAM;
            SG_DATA:            next_byte = i_pattern;
            default:            next_byte = B_ZERO;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_byte <= B_ZERO;
        end else begin
            o_byte <= next_byte;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_idam_byte;
        i_seg == SG_IDAM |=> o_byte == B_IDAM;
    endproperty
    a_idam_byte: assert property (p_idam_byte) else $error("id mark byte wrong"); // RULE_03

    property p_zero_fill;
        !i_dbl && i_fill_zero && i_seg == SG_GAP2 |=> o_byte == B_ZERO;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("zero fill not used"); // RULE_06

    property p_sync_mark;
        i_dbl && (i_seg == SG_IDA1 || i_seg == SG_DA1) |=> o_byte == B_SYNC_A1;
    endproperty
    a_sync_mark: assert property (p_sync_mark) else $error("sync byte wrong"); // RULE_11
endmodule // fts_layout

// ### design/fts_strobe.sv
// write-strobe engine: one timed load of the byte holding register
// assumes the controller drops its request within the recovery wait
`timescale 1ns/10ps
module fts_strobe
    import fts_pkg::*;
(
    input  wire logic  i_mclk,
    input  wire logic  i_rst,
    fts_wr_if.slave    wr,
    output logic [7:0] o_data,
    output logic       o_data_oe,
    output logic       o_wr_strobe_n
);
    typedef enum logic [2:0] {
        W_IDLE = 3'b000, W_SETUP = 3'b001, W_PULSE = 3'b010,
        W_HOLD = 3'b011, W_RECOV = 3'b100
    } fts_wst_type;

    fts_wst_type st, next_st;
    logic [7:0]  cnt, next_cnt;
    logic [7:0]  next_data;
    logic        next_oe, next_strobe_n;

    always_comb begin
        next_st = st;
        next_cnt = cnt - 8'h01;
        next_data = o_data;
        next_oe = o_data_oe;
        next_strobe_n = o_wr_strobe_n;
        wr.done = 1'b0;
        case (st)
            W_IDLE: begin
                next_cnt = cnt;
                if (wr.go) begin
                    next_st = W_SETUP;
                    next_data = wr.data;
                    next_oe = 1'b1;
                    next_cnt = 8'(DS_CYC - 1);
                end
            end
            W_SETUP: if (cnt == 8'h00) begin
                next_st = W_PULSE;
                next_strobe_n = 1'b0;
                next_cnt = 8'(WE_CYC - 1);
            end
            W_PULSE: if (cnt == 8'h00) begin
                next_st = W_HOLD;
                next_strobe_n = 1'b1;
                next_cnt = 8'(DH_CYC - 1);
            end
            W_HOLD: if (cnt == 8'h00) begin
                next_st = W_RECOV;
                next_oe = 1'b0;
                next_cnt = 8'(DRR_CYC - 1);
            end
            W_RECOV: if (cnt == 8'h00) begin
                // request line is settled only after this wait
                next_st = W_IDLE;
                wr.done = 1'b1;
            end
            default: next_st = W_IDLE;
        endcase
    end

    assign wr.busy = (st != W_IDLE);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= W_IDLE;
            cnt <= 8'h00;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
            o_wr_strobe_n <= 1'b1;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            o_data <= next_data;
            o_data_oe <= next_oe;
            o_wr_strobe_n <= next_strobe_n;
        end
    end

    logic [7:0] low_len;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            low_len <= 8'h00;
        end else begin
            low_len <= o_wr_strobe_n ? 8'h00 : low_len + 8'h01;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_we_width;
        $rose(o_wr_strobe_n) |-> low_len == 8'(WE_CYC);
    endproperty
    a_we_width: assert property (p_we_width) else $error("strobe width wrong"); // RULE_01

    property p_data_steady;
        o_data_oe && $past(o_data_oe) |-> $stable(o_data);
    endproperty
    a_data_steady: assert property (p_data_steady) else $error("data moved"); // RULE_01

    property p_strobe_driven;
        !o_wr_strobe_n |-> o_data_oe;
    endproperty
    a_strobe_driven: assert property (p_strobe_driven) else $error("strobe undriven"); // RULE_01
endmodule // fts_strobe

// ### design/fts_track_host.sv
// host side of a track write: feeds the track image one byte per request
// assumes the write-track command is already issued to the controller
//
// Notes on behaviour
// RULE_01 - one byte loaded into the holding register for every request
// RULE_02 - FM track opens 40 fill, 6 zeros, FC, 26 fill
// RULE_03 - FM sector record: zeros, FE, id, F7, gap, zeros, FB, data, F7, gap
// RULE_04 - sector record repeated 26 times in either density
// RULE_05 - after last sector keep sending fill until command done
// RULE_06 - FM gap fill may be 00 instead of FF
// RULE_07 - MFM track opens 80 4E, 12 zeros, three F6, FC, 4E gap
// RULE_08 - MFM sector record uses 12 zeros, three F5, 256 data bytes
// RULE_09 - sector size only 128, 256, 512 or 1024 bytes
// RULE_10 - gap between id record and data mark stays standard
// RULE_11 - MFM: exactly three F5 sync loads before each address mark
// RULE_12 - controller copes with a track lacking the index mark
// RULE_13 - gaps 1, 3, 4 may shrink to 2 bytes; longer is safer
// RULE_14 - minimal FM gaps: gap II 11 FF plus 6 zeros exactly
// RULE_15 - minimal MFM gaps: gap II 22 4E, 12 zeros, three A1
// RULE_16 - prefer the standard layouts for reliability
// RULE_17 - an F7 load makes the controller write two CRC bytes
// RULE_18 - controller writes zero when no byte arrived in time
// RULE_19 - writing runs index to index; controller then signals done
`timescale 1ns/10ps
module fts_track_host
    import fts_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic       i_double,
    input  wire logic       i_fill_zero,
    input  wire logic       i_omit_index,
    input  wire logic [1:0] i_size_code,
    input  wire logic [7:0] i_track,
    input  wire logic [7:0] i_side,
    input  wire logic [7:0] i_pattern,
    input  wire logic       i_byte_request_line,
    input  wire logic       i_command_done_line,
    output logic            o_density_select_line_n,
    output logic [7:0]      o_data,
    output logic            o_data_oe,
    output logic            o_wr_strobe_n,
    output logic            o_busy,
    output logic            o_done
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_WAIT   = 3'b010,
        ST_LOAD   = 3'b011,
        ST_DONE   = 3'b100
    } fts_state_type;

    fts_state_type state, next_state;
    fts_seg_type   seg, next_seg, follow;
    logic [10:0]   rem, next_rem;
    logic [4:0]    sector, next_sector;
    logic          dbl, next_dbl;
    logic          fill_zero, next_fill_zero;
    logic          omit, next_omit;
    logic [1:0]    size_code, next_size_code;
    logic [7:0]    track, next_track;
    logic [7:0]    side, next_side;
    logic [7:0]    pattern, next_pattern;
    logic          next_done;
    logic [7:0]    cur_byte;

    fts_wr_if wr ();

    fts_layout u_layout (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_seg       (seg),
        .i_dbl       (dbl),
        .i_fill_zero (fill_zero),
        .i_track     (track),
        .i_side      (side),
        .i_sector    (sector),
        .i_size_code (size_code),
        .i_pattern   (pattern),
        .o_byte      (cur_byte)
    );

    fts_strobe u_strobe (
        .i_mclk        (i_mclk),
        .i_rst         (i_rst),
        .wr            (wr.slave),
        .o_data        (o_data),
        .o_data_oe     (o_data_oe),
        .o_wr_strobe_n (o_wr_strobe_n)
    );

    // order of segments through the track image
    always_comb begin
        case (seg)
            SG_GAP0:   follow = SG_SYNC0;
            SG_SYNC0:  follow = SG_IAMPRE;
            SG_IAMPRE: follow = SG_IAM;
            SG_IAM:    follow = SG_GAP1;
            SG_GAP1:   follow = SG_IDSYNC;
            SG_IDSYNC: follow = SG_IDA1;
            SG_IDA1:   follow = SG_IDAM;
            SG_IDAM:   follow = SG_TRK;
            SG_TRK:    follow = SG_SIDE;
            SG_SIDE:   follow = SG_SEC;
            SG_SEC:    follow = SG_LEN;
            SG_LEN:    follow = SG_IDCRC;
            SG_IDCRC:  follow = SG_GAP2;
            SG_GAP2:   follow = SG_DSYNC;
            SG_DSYNC:  follow = SG_DA1;
            SG_DA1:    follow = SG_DAM;
            SG_DAM:    follow = SG_DATA;
            SG_DATA:   follow = SG_DCRC;
            SG_DCRC:   follow = SG_GAP3;
            SG_GAP3:   follow = (sector == SECTORS) ? SG_GAP4 : SG_IDSYNC; // RULE_04
            default:   follow = SG_GAP4; // RULE_05
        endcase
    end

    always_comb begin
        next_state = state;
        next_seg = seg;
        next_rem = rem;
        next_sector = sector;
        next_dbl = dbl;
        next_fill_zero = fill_zero;
        next_omit = omit;
        next_size_code = size_code;
        next_track = track;
        next_side = side;
        next_pattern = pattern;
        next_done = 1'b0;
        wr.go = 1'b0;
        wr.data = cur_byte;
        case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_state = ST_SETTLE;
                    next_seg = SG_GAP0;
                    next_rem = fts_seg_len(SG_GAP0, i_double, i_omit_index,
                                           i_size_code); // RULE_02
                    next_sector = FIRST_SEC;
                    next_dbl = i_double;
                    next_fill_zero = i_fill_zero;
                    next_omit = i_omit_index; // RULE_12
                    next_size_code = i_size_code; // RULE_09
                    next_track = i_track;
                    next_side = i_side;
                    next_pattern = i_pattern;
                end
            end
            ST_SETTLE: begin
                // stay one cycle so the layout byte matches the segment
                if (i_command_done_line) begin
                    next_state = ST_DONE; // RULE_19
                end else if (rem == N_NONE) begin
                    next_seg = follow;
                    next_rem = fts_seg_len(follow, dbl, omit, size_code); // RULE_10
                    if (seg == SG_GAP3 && sector != SECTORS) begin
                        next_sector = sector + FIRST_SEC;
                    end
                end else begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_command_done_line) begin
                    next_state = ST_DONE; // RULE_19
                end else if (i_byte_request_line && !wr.busy) begin
                    wr.go = 1'b1; // RULE_01
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (wr.done) begin
                    if (i_command_done_line) begin
                        next_state = ST_DONE;
                    end else begin
                        next_state = ST_SETTLE;
                        // trailing fill never runs out
                        if (seg != SG_GAP4) begin
                            next_rem = rem - N_ONE; // RULE_05
                        end
                    end
                end
            end
            ST_DONE: begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            seg <= SG_GAP0;
            rem <= N_NONE;
            sector <= FIRST_SEC;
            dbl <= 1'b0;
            fill_zero <= 1'b0;
            omit <= 1'b0;
            size_code <= 2'h0;
            track <= 8'h00;
            side <= 8'h00;
            pattern <= 8'h00;
            o_done <= 1'b0;
        end else begin
            state <= next_state;
            seg <= next_seg;
            rem <= next_rem;
            sector <= next_sector;
            dbl <= next_dbl;
            fill_zero <= next_fill_zero;
            omit <= next_omit;
            size_code <= next_size_code;
            track <= next_track;
            side <= next_side;
            pattern <= next_pattern;
            o_done <= next_done;
        end
    end

    // density line is low for the double-density layout
    assign o_density_select_line_n = ~dbl; // RULE_08
    assign o_busy = (state != ST_IDLE);

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_go_on_request;
        wr.go |-> i_byte_request_line && state == ST_WAIT;
    endproperty
    a_go_on_request: assert property (p_go_on_request) else $error("load without request"); // RULE_01

    property p_single_load;
        wr.go |=> !wr.go [*8];
    endproperty
    a_single_load: assert property (p_single_load) else $error("two loads on one request"); // RULE_01

    property p_sector_range;
        o_busy |-> sector >= FIRST_SEC && sector <= SECTORS;
    endproperty
    a_sector_range: assert property (p_sector_range) else $error("sector out of range"); // RULE_04

    property p_tail_after_last;
        o_busy && seg == SG_GAP4 |-> sector == SECTORS;
    endproperty
    a_tail_after_last: assert property (p_tail_after_last) else $error("tail fill too early"); // RULE_05

    property p_data_size;
        state == ST_SETTLE && seg == SG_DATA && $past(seg) != SG_DATA
            |-> rem == 11'(N_DATA_MIN << size_code);
    endproperty
    a_data_size: assert property (p_data_size) else $error("data field size wrong"); // RULE_09

    property p_gap2_len;
        state == ST_SETTLE && seg == SG_GAP2 && $past(seg) != SG_GAP2
            |-> rem == (dbl ? N_GAP2_MFM : N_GAP2_FM);
    endproperty
    a_gap2_len: assert property (p_gap2_len) else $error("gap after id altered"); // RULE_10

    property p_density_steady;
        o_busy && $past(o_busy) |-> $stable(o_density_select_line_n);
    endproperty
    a_density_steady: assert property (p_density_steady) else $error("density moved"); // RULE_07

    sequence s_finish;
        state == ST_DONE ##1 (o_done && state == ST_IDLE);
    endsequence

    property p_stop_on_done;
        i_command_done_line && (state == ST_WAIT || state == ST_SETTLE) |=> s_finish;
    endproperty
    a_stop_on_done: assert property (p_stop_on_done) else $error("no stop at done"); // RULE_19
endmodule // fts_track_host

// ### dv/fts_ctrl_model.sv
// behavioural disk controller seen from the host: takes one byte per request
// assumes the host strobe pulse is well inside the request window
`timescale 1ns/10ps
module fts_ctrl_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_arm,
    input  wire logic        i_slow,
    input  wire logic [15:0] i_n_bytes,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_data_oe,
    input  wire logic        i_wr_strobe_n,
    output logic             o_req,
    output logic             o_done
);
    logic [7:0] got [$];
    logic       strobe_q;
    int         gap;
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_req    <= 1'b0;
            o_done   <= 1'b0;
            strobe_q <= 1'b1;
            gap      <= -1;
        end else begin
            strobe_q <= i_wr_strobe_n;
            if (i_arm) begin
                got.delete();
                o_done <= 1'b0;
                o_req  <= 1'b1;
                gap    <= -1;
            end else if (strobe_q && !i_wr_strobe_n) begin
                o_req <= 1'b0;
            end else if (!strobe_q && i_wr_strobe_n) begin
                // index mark not needed: any byte order is taken; f7 kept as crc request
                got.push_back(i_data_oe ? i_data : 8'hxx);
                // slow gap outlasts the host recovery, so the host really waits
                gap <= i_slow ? 100 : 1;
            end else if (gap > 0) begin
                gap <= gap - 1;
            end else if (gap == 0) begin
                // end of command may land while the host waits for a request
                if (got.size() >= int'(i_n_bytes)) begin
                    o_done <= 1'b1;
                end else begin
                    o_req <= 1'b1;
                end
                gap <= -1;
            end
        end
    end
endmodule // fts_ctrl_model

// ### dv/fts_track_host_tb.sv
// self-checking bench for the track-image host against a controller model
// assumes track runs are cut short by the model's end-of-command count
`timescale 1ns/10ps
module fts_track_host_tb;
    logic       i_mclk, i_rst, i_start, i_double, i_fill_zero, i_omit_index;
    logic [1:0] i_size_code;
    logic [7:0] i_track, i_side, i_pattern, o_data;
    logic       arm, slow, req, cmd_done, o_density_select_line_n;
    logic       o_data_oe, o_wr_strobe_n, o_busy, o_done;
    logic [15:0] n_bytes;
    logic [7:0] exp_q [$];
    int         error_cnt, samples_checked;

    fts_track_host i_fts_track_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start),
        .i_double(i_double), .i_fill_zero(i_fill_zero), .i_omit_index(i_omit_index),
        .i_size_code(i_size_code), .i_track(i_track), .i_side(i_side),
        .i_pattern(i_pattern), .i_byte_request_line(req), .i_command_done_line(cmd_done),
        .o_density_select_line_n(o_density_select_line_n), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_wr_strobe_n(o_wr_strobe_n), .o_busy(o_busy),
        .o_done(o_done));
    fts_ctrl_model i_fts_ctrl_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_arm(arm),
        .i_slow(slow), .i_n_bytes(n_bytes), .i_data(o_data), .i_data_oe(o_data_oe),
        .i_wr_strobe_n(o_wr_strobe_n), .o_req(req), .o_done(cmd_done));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // runs one image; a second start midway must be ignored
    task automatic run_image();
        int k;
        @(negedge i_mclk);
        i_start = 1'b1;
        arm = 1'b1;
        @(negedge i_mclk);
        i_start = 1'b0;
        arm = 1'b0;
        for (k = 0; k < 80000 && o_done !== 1'b1; k++) begin
            @(negedge i_mclk);
            i_start = (k == 2000);
        end
        check({15'h0, o_busy}, 16'h0000);
        check({15'h0, o_density_select_line_n}, {15'h0, !i_double});
        check(16'(i_fts_ctrl_model.got.size()), 16'(exp_q.size()));
        for (k = 0; k < exp_q.size(); k++)
            check({8'h00, i_fts_ctrl_model.got[k]}, {8'h00, exp_q[k]});
    endtask

    task automatic load_exp(input int cnt [], input logic [7:0] val []);
        exp_q.delete();
        foreach (cnt[i])
            repeat (cnt[i]) exp_q.push_back(val[i]);
        n_bytes = 16'(exp_q.size());
    endtask

    task automatic t_reset();
        check({8'h00, o_data}, 16'h0000);
        check({12'h0, o_data_oe, o_wr_strobe_n, o_busy, o_density_select_line_n}, 16'h0005);
        $display("test reset done");
    endtask

    // fm with zero fill, first sector whole plus three id sync zeros of the second
    task automatic t_fm();
        int         c [] = '{40, 6, 1, 26, 6, 1, 1, 1, 1, 1, 1, 11, 6, 1, 128, 1, 27, 3};
        logic [7:0] v [] = '{8'h00, 8'h00, 8'hfc, 8'h00, 8'h00, 8'hfe, 8'h05, 8'h01, 8'h01,
                             8'h00, 8'hf7, 8'h00, 8'h00, 8'hfb, 8'he5, 8'hf7, 8'h00, 8'h00};
        i_double = 1'b0;
        i_fill_zero = 1'b1;
        i_omit_index = 1'b0;
        i_size_code = 2'h0;
        i_track = 8'h05;
        i_side = 8'h01;
        i_pattern = 8'he5;
        slow = 1'b0;
        load_exp(c, v);
        run_image();
        $display("test fm done");
    endtask

    // mfm without index group, slow requests, id record, gap II and two data sync zeros
    task automatic t_mfm();
        int         c [] = '{80, 50, 12, 3, 1, 1, 1, 1, 1, 1, 22, 2};
        logic [7:0] v [] = '{8'h4e, 8'h4e, 8'h00, 8'hf5, 8'hfe, 8'h4c, 8'h00, 8'h01, 8'h01,
                             8'hf7, 8'h4e, 8'h00};
        i_double = 1'b1;
        i_fill_zero = 1'b0;
        i_omit_index = 1'b1;
        i_size_code = 2'h1;
        i_track = 8'h4c;
        i_side = 8'h00;
        slow = 1'b1;
        load_exp(c, v);
        run_image();
        $display("test mfm done");
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    initial begin
        repeat (90000) @(posedge i_mclk);
        error_cnt++;
        summarize();
    end

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        {i_start, i_double, i_fill_zero, i_omit_index, arm, slow} = 6'h00;
        {i_size_code, i_track, i_side, i_pattern, n_bytes} = '0;
        i_rst = 1'b1;
        repeat (16) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 1'b0;
        t_reset();
        t_fm();
        t_mfm();
        summarize();
    end
endmodule // fts_track_host_tb
